// File: rtl/mcu_pc_pkg.sv
/*
 Shared constants, types and carriers for the fetch pipeline and program counter.
 Assumes one system clock and a word-wide program memory on the far side.
*/
package mcu_pc_pkg;
    localparam int PC_W = 11;
    localparam int PCL_W = 8;
    localparam int PCH_W = 3;
    localparam int WORD_W = 16;
    localparam int DATA_W = 8;
    localparam int REG_AW = 4;
    localparam int PHASES = 4;
    localparam int SLOW_DIV_DEFAULT = 8;

    localparam logic [PC_W-1:0] RESET_VECTOR = 11'h000;
    localparam logic [PC_W-1:0] PC_STEP = 11'h001;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

    // Register offsets
    localparam logic [REG_AW-1:0] REG_PCL = 4'h0;
    localparam logic [REG_AW-1:0] REG_ACC = 4'h1;
    localparam logic [REG_AW-1:0] REG_STATUS = 4'h2;
    localparam logic [REG_AW-1:0] REG_CLK_CTRL = 4'h3;

    // Field positions
    localparam int ST_PHASE_LSB = 0;
    localparam int ST_DUMMY = 2;
    localparam int ST_SW_PEND = 3;
    localparam int ST_OSC_SLOW = 4;
    localparam int CLK_SLOW_BIT = 0;
    localparam int OP_MSB = 15;
    localparam int OP_LSB = 13;
    localparam int TGT_MSB = 10;
    localparam int IMM_MSB = 7;

    typedef enum logic [2:0] {
        OP_NOP = 3'h0,
        OP_ADDI = 3'h1,
        OP_JMP = 3'h2,
        OP_CALL = 3'h3,
        OP_SKZ = 3'h4,
        OP_WR_PCL = 3'h5,
        OP_RD_PCL = 3'h6,
        OP_LDI = 3'h7
    } opcode_t;

    typedef enum logic [1:0] {
        PH_T1 = 2'h0,
        PH_T2 = 2'h1,
        PH_T3 = 2'h2,
        PH_T4 = 2'h3
    } phase_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [REG_AW-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic rd;
        logic [PC_W-1:0] addr;
    } fetch_req_t;

    typedef struct packed {
        logic push;
        logic [PC_W-1:0] ret_addr;
    } stack_push_t;
endpackage

// File: rtl/osc_tick_gen.sv
/*
 Phase-advance tick from the fast or slow internal oscillator.
 Assumes the select comes from a register on sys_clk, so no synchroniser.
*/
`timescale 1ns/1ns
module osc_tick_gen #(
    parameter int SLOW_DIV = mcu_pc_pkg::SLOW_DIV_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic slow_sel,
    output logic tick_reg
);
    localparam int CW = $clog2(SLOW_DIV);
    localparam logic [CW-1:0] LAST = CW'(SLOW_DIV - 1);

    logic [CW-1:0] div_reg;

    generate
        if (SLOW_DIV < 2) begin : g_bad
            $error("SLOW_DIV must be at least 2");
        end
    endgenerate

    // Slow source stretches each phase over SLOW_DIV system clocks
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= '0;
            tick_reg <= 1'b0;
        end else if (!slow_sel) begin
            div_reg <= '0;
            tick_reg <= 1'b1;
        end else begin
            div_reg <= (div_reg == LAST) ? '0 : CW'(div_reg + 1'b1);
            tick_reg <= (div_reg == LAST);
        end
    end
endmodule

// File: rtl/phase_seq.sv
/*
 Four-phase sequencer: one-hot non-overlapping phase strobes.
 Assumes a one-cycle tick per phase step on the same clock.
*/
`timescale 1ns/1ns
module phase_seq (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic tick,
    output mcu_pc_pkg::phase_t phase_reg,
    output logic [mcu_pc_pkg::PHASES-1:0] phase_clk_reg
);
    mcu_pc_pkg::phase_t phase_next;

    always_comb begin
        case (phase_reg)
            mcu_pc_pkg::PH_T1: phase_next = mcu_pc_pkg::PH_T2;
            mcu_pc_pkg::PH_T2: phase_next = mcu_pc_pkg::PH_T3;
            mcu_pc_pkg::PH_T3: phase_next = mcu_pc_pkg::PH_T4;
            mcu_pc_pkg::PH_T4: phase_next = mcu_pc_pkg::PH_T1;
            default: phase_next = mcu_pc_pkg::PH_T1;
        endcase
    end

    // Start in T4 so the first tick opens a T1 fetch
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= mcu_pc_pkg::PH_T4;
            phase_clk_reg <= 4'h8;
        end else if (tick) begin
            phase_reg <= phase_next;
            phase_clk_reg <= 4'h1 << phase_next;
        end
    end
endmodule

// File: rtl/mcu_fetch_pipeline_pc.sv
/*
 Instruction fetch pipeline and 11-bit program counter of a small 8-bit core,
 with a minimal accumulator datapath and a byte-wide register port.
 Assumes program memory answers within one instruction cycle and that
 stack storage and interrupt arbitration sit outside.
*/
// The register offsets and the address-and-strobe port were left to the implementer.
// Function
// - The phase rate comes from either the fast or the slow internal oscillator.
// - The clock is split into four non-overlapping phases forming one instruction cycle.
// - At the start of the first phase the counter advances and a new fetch begins.
// - Phases two to four decode and execute the current instruction.
// - Fetch of the next word overlaps execution, so plain instructions take one cycle.
// - Any instruction that changes the counter costs one extra cycle.
// - A branch spends its first cycle getting the target and its second branching.
// - The counter steps by one unless a non-consecutive transfer is needed.
// - Jumps, calls, interrupts and reset load their target straight into the counter.
// - A taken skip discards the prefetched word and runs a dummy cycle.
// - The counter is three high bits plus an eight-bit low byte.
// - Only the low byte is reachable by software; the high bits are not.
// - Operations go through an eight-bit ALU and the accumulator.
// - Reset sets the counter to address zero and execution starts there.
// - A software write to the low byte jumps within the page and inserts a dummy cycle.
`timescale 1ns/1ns
module mcu_fetch_pipeline_pc #(
    parameter int SLOW_DIV = mcu_pc_pkg::SLOW_DIV_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input mcu_pc_pkg::reg_req_t reg_req,
    output logic [mcu_pc_pkg::DATA_W-1:0] reg_rdata_reg,
    input wire logic [mcu_pc_pkg::WORD_W-1:0] mem_data,
    output mcu_pc_pkg::fetch_req_t mem_req_reg,
    input wire logic int_req,
    input wire logic [mcu_pc_pkg::PC_W-1:0] int_vec,
    output logic int_ack_reg,
    output mcu_pc_pkg::stack_push_t stack_push_reg,
    output logic [mcu_pc_pkg::PHASES-1:0] instruction_phase_clocks,
    output logic [mcu_pc_pkg::PCH_W-1:0] program_counter_high_bits
);
    localparam int PC_W = mcu_pc_pkg::PC_W;
    localparam int DW = mcu_pc_pkg::DATA_W;
    localparam int WW = mcu_pc_pkg::WORD_W;
    localparam int PHASE_W = $bits(mcu_pc_pkg::phase_t);

    generate
        if (PC_W != mcu_pc_pkg::PCH_W + mcu_pc_pkg::PCL_W) begin : g_bad_pc
            $error("Counter width must equal high bits plus low byte");
        end
        // Divider must be at least 2; field layout must agree with the slices the logic takes
        if (SLOW_DIV < 2) begin : g_bad_div
            $error("SLOW_DIV must be at least 2");
        end
        if (mcu_pc_pkg::TGT_MSB != PC_W - 1) begin : g_bad_tgt
            $error("Target field must span the counter");
        end
        if (mcu_pc_pkg::IMM_MSB != DW - 1) begin : g_bad_imm
            $error("Immediate field must be one byte");
        end
        if (mcu_pc_pkg::ST_OSC_SLOW >= DW) begin : g_bad_st
            $error("Status fields must fit the read byte");
        end
        if (mcu_pc_pkg::OP_MSB - mcu_pc_pkg::OP_LSB + 1 != $bits(mcu_pc_pkg::opcode_t)) begin : g_bad_op
            $error("Opcode field must match the opcode width");
        end
    endgenerate

    // Page-relative target: high bits kept, low byte replaced
    function automatic logic [PC_W-1:0] page_target(
        input logic [PC_W-1:0] base,
        input logic [DW-1:0] low
    );
        page_target = {base[PC_W-1:DW], low};
    endfunction

    function automatic mcu_pc_pkg::opcode_t op_of(input logic [WW-1:0] word);
        op_of = mcu_pc_pkg::opcode_t'(word[mcu_pc_pkg::OP_MSB:mcu_pc_pkg::OP_LSB]);
    endfunction

    function automatic logic reg_hit(
        input mcu_pc_pkg::reg_req_t req,
        input logic [mcu_pc_pkg::REG_AW-1:0] offset
    );
        reg_hit = (req.addr == offset);
    endfunction

    // Status byte: phase, dummy flag, pending low-byte write, slow oscillator
    function automatic logic [DW-1:0] status_byte(
        input mcu_pc_pkg::phase_t ph,
        input logic dummy,
        input logic pend,
        input logic slow
    );
        logic [DW-1:0] st;
        st = mcu_pc_pkg::ZERO_BYTE;
        st[mcu_pc_pkg::ST_PHASE_LSB +: PHASE_W] = ph;
        st[mcu_pc_pkg::ST_DUMMY] = dummy;
        st[mcu_pc_pkg::ST_SW_PEND] = pend;
        st[mcu_pc_pkg::ST_OSC_SLOW] = slow;
        status_byte = st;
    endfunction

    // Program counter, split into page bits and low byte
    logic [PC_W-1:0] pc_reg;
    logic [PC_W-1:0] pc_next;

    // Instruction register and pipeline state
    logic [WW-1:0] ir_reg;
    logic ir_valid_reg;
    logic primed_reg;
    logic [DW-1:0] acc_reg;
    logic [DW-1:0] acc_next;

    // Software side
    logic osc_slow_reg;
    logic pcl_pend_reg;
    logic [DW-1:0] pcl_val_reg;

    // Phase timing
    logic phase_tick;
    mcu_pc_pkg::phase_t phase;
    logic cycle_end;

    // Execute decode
    mcu_pc_pkg::opcode_t op;
    logic exec_branch;
    logic [PC_W-1:0] exec_target;
    logic int_take;
    logic sw_take;
    logic push_take;
    logic pcl_wr_hit;
    logic clk_wr_hit;
    logic redirect;
    logic [PC_W-1:0] redirect_addr;
    logic [PC_W-1:0] fetch_addr;
    logic [mcu_pc_pkg::PHASES-1:0] phase_clk;

    osc_tick_gen #(
        .SLOW_DIV(SLOW_DIV)
    ) u_osc (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .slow_sel(osc_slow_reg),
        .tick_reg(phase_tick)
    );

    phase_seq u_phase (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .tick(phase_tick),
        .phase_reg(phase),
        .phase_clk_reg(phase_clk)
    );

    assign instruction_phase_clocks = phase_clk;

    // The T4 step is the boundary: execution retires and T1 begins
    assign cycle_end = phase_tick && (phase == mcu_pc_pkg::PH_T4);

    assign program_counter_high_bits = pc_reg[PC_W-1:DW];

    // Decode of the word in execution; effects land at the cycle boundary
    always_comb begin
        op = op_of(ir_reg);
        exec_branch = 1'b0;
        exec_target = pc_reg;
        if (ir_valid_reg) begin
            case (op)
                mcu_pc_pkg::OP_JMP: begin
                    exec_branch = 1'b1;
                    exec_target = ir_reg[mcu_pc_pkg::TGT_MSB:0];
                end
                mcu_pc_pkg::OP_CALL: begin
                    exec_branch = 1'b1;
                    exec_target = ir_reg[mcu_pc_pkg::TGT_MSB:0];
                end
                mcu_pc_pkg::OP_SKZ: begin
                    // Prefetched word is dropped; resume one past it
                    exec_branch = (acc_reg == mcu_pc_pkg::ZERO_BYTE);
                    exec_target = pc_reg;
                end
                mcu_pc_pkg::OP_WR_PCL: begin
                    exec_branch = 1'b1;
                    exec_target = page_target(pc_reg, acc_reg);
                end
                default: begin
                    exec_branch = 1'b0;
                    exec_target = pc_reg;
                end
            endcase
        end
    end

    // Interrupts only at a real instruction boundary, never during a dummy
    assign int_take = int_req && ir_valid_reg && !exec_branch;
    assign sw_take = pcl_pend_reg && !exec_branch && !int_take;
    assign redirect = exec_branch || int_take || sw_take;
    // Calls and interrupts hand the dropped prefetch address to the stack
    assign push_take = cycle_end && (int_take || (exec_branch && op == mcu_pc_pkg::OP_CALL));

    // Register decodes shared by the write side
    assign pcl_wr_hit = reg_req.wr && reg_hit(reg_req, mcu_pc_pkg::REG_PCL);
    assign clk_wr_hit = reg_req.wr && reg_hit(reg_req, mcu_pc_pkg::REG_CLK_CTRL);

    // Page bits of a software jump come from the counter at the consuming boundary
    always_comb begin
        if (exec_branch) begin
            redirect_addr = exec_target;
        end else if (int_take) begin
            redirect_addr = int_vec;
        end else begin
            redirect_addr = page_target(pc_reg, pcl_val_reg);
        end
    end

    assign fetch_addr = redirect ? redirect_addr : pc_reg;
    assign pc_next = PC_W'(fetch_addr + mcu_pc_pkg::PC_STEP);

    // Counter advances as T1 opens
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_reg <= mcu_pc_pkg::RESET_VECTOR;
        end else if (cycle_end) begin
            pc_reg <= pc_next;
        end
    end

    // Fetch request for the word executed next cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_req_reg.rd <= 1'b0;
            mem_req_reg.addr <= mcu_pc_pkg::RESET_VECTOR;
        end else if (cycle_end) begin
            mem_req_reg.rd <= 1'b1;
            mem_req_reg.addr <= fetch_addr;
        end else begin
            mem_req_reg.rd <= 1'b0;
        end
    end

    // Nothing is in flight before the first fetch, so the first load is a dummy
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            primed_reg <= 1'b0;
        end else if (cycle_end) begin
            primed_reg <= 1'b1;
        end
    end

    // Prefetched word becomes the executing one; a redirect turns it into a dummy
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_reg <= mcu_pc_pkg::WORD_RESET;
            ir_valid_reg <= 1'b0;
        end else if (cycle_end) begin
            ir_reg <= mem_data;
            ir_valid_reg <= !redirect && primed_reg;
        end
    end

    // Accumulator datapath, eight bits wide
    always_comb begin
        acc_next = acc_reg;
        if (ir_valid_reg) begin
            case (op)
                mcu_pc_pkg::OP_ADDI: acc_next = DW'(acc_reg + ir_reg[mcu_pc_pkg::IMM_MSB:0]);
                mcu_pc_pkg::OP_LDI: acc_next = ir_reg[mcu_pc_pkg::IMM_MSB:0];
                mcu_pc_pkg::OP_RD_PCL: acc_next = pc_reg[DW-1:0];
                default: acc_next = acc_reg;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg <= mcu_pc_pkg::ACC_RESET;
        end else if (cycle_end) begin
            acc_reg <= acc_next;
        end
    end

    // Return address for calls and interrupts: the word that was discarded
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stack_push_reg.push <= 1'b0;
            stack_push_reg.ret_addr <= mcu_pc_pkg::RESET_VECTOR;
        end else if (push_take) begin
            stack_push_reg.push <= 1'b1;
            stack_push_reg.ret_addr <= mem_req_reg.addr;
        end else begin
            stack_push_reg.push <= 1'b0;
        end
    end

    // Ack lands with the stack push, one pulse per taken interrupt
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_ack_reg <= 1'b0;
        end else begin
            int_ack_reg <= cycle_end && int_take;
        end
    end

    // Low-byte write held until a boundary; a new write beats the consume
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pcl_pend_reg <= 1'b0;
            pcl_val_reg <= mcu_pc_pkg::ZERO_BYTE;
        end else if (pcl_wr_hit) begin
            pcl_pend_reg <= 1'b1;
            pcl_val_reg <= reg_req.wdata;
        end else if (cycle_end && sw_take) begin
            pcl_pend_reg <= 1'b0;
        end
    end

    // Oscillator choice; switching mid-cycle only stretches (to slow) or shortens (to fast) the current phase
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_slow_reg <= 1'b0;
        end else if (clk_wr_hit) begin
            osc_slow_reg <= reg_req.wdata[mcu_pc_pkg::CLK_SLOW_BIT];
        end
    end

    // Read port: data valid the cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_reg <= mcu_pc_pkg::ZERO_BYTE;
        end else if (reg_req.rd) begin
            reg_rdata_reg <= mcu_pc_pkg::ZERO_BYTE;
            case (reg_req.addr)
                mcu_pc_pkg::REG_PCL: reg_rdata_reg <= pc_reg[DW-1:0];
                mcu_pc_pkg::REG_ACC: reg_rdata_reg <= acc_reg;
                mcu_pc_pkg::REG_STATUS: reg_rdata_reg <= status_byte(phase, !ir_valid_reg, pcl_pend_reg, osc_slow_reg);
                mcu_pc_pkg::REG_CLK_CTRL: reg_rdata_reg[mcu_pc_pkg::CLK_SLOW_BIT] <= osc_slow_reg;
                default: reg_rdata_reg <= mcu_pc_pkg::ZERO_BYTE;
            endcase
        end else begin
            reg_rdata_reg <= mcu_pc_pkg::ZERO_BYTE;
        end
    end
endmodule

// File: bench/mcu_fetch_pipeline_pc_asserts.sv
/*
 Port-level checker for the fetch pipeline and program counter.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ns
module mcu_fetch_pipeline_pc_asserts #(
    parameter int SLOW_DIV = mcu_pc_pkg::SLOW_DIV_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire mcu_pc_pkg::reg_req_t reg_req,
    input wire logic [mcu_pc_pkg::DATA_W-1:0] reg_rdata_reg,
    input wire logic [mcu_pc_pkg::WORD_W-1:0] mem_data,
    input wire mcu_pc_pkg::fetch_req_t mem_req_reg,
    input wire logic int_req,
    input wire logic [mcu_pc_pkg::PC_W-1:0] int_vec,
    input wire logic int_ack_reg,
    input wire mcu_pc_pkg::stack_push_t stack_push_reg,
    input wire logic [mcu_pc_pkg::PHASES-1:0] instruction_phase_clocks,
    input wire logic [mcu_pc_pkg::PCH_W-1:0] program_counter_high_bits
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    logic seen_reg;
    logic [10:0] nxt_addr;
    assign nxt_addr = mem_req_reg.addr + 11'h001;

    // First fetch after reset must be told apart from the rest
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_reg <= 1'b0;
        end else if (mem_req_reg.rd) begin
            seen_reg <= 1'b1;
        end
    end

    AST_PHASE_ONEHOT: assert property ($onehot(instruction_phase_clocks))
        else $error("phase strobes not one-hot");
    AST_FETCH_IN_T1: assert property (mem_req_reg.rd |-> instruction_phase_clocks == 4'h1)
        else $error("fetch outside first phase");
    AST_T1_STARTS_FETCH: assert property ($rose(instruction_phase_clocks[0]) |-> mem_req_reg.rd)
        else $error("first phase without fetch");
    AST_T1_TO_T2: assert property ($fell(instruction_phase_clocks[0]) |-> instruction_phase_clocks[1])
        else $error("second phase does not follow first");
    AST_FETCH_SPACING: assert property (mem_req_reg.rd |=> !mem_req_reg.rd [*3])
        else $error("fetches closer than four clocks");
    AST_ADDR_HOLDS: assert property (!mem_req_reg.rd |-> $stable(mem_req_reg.addr))
        else $error("fetch address moved between fetches");
    AST_HIGH_BITS: assert property (mem_req_reg.rd |-> program_counter_high_bits == nxt_addr[10:8])
        else $error("high bits differ from counter");
    AST_RDATA_IDLE: assert property (!$past(reg_req.rd) |-> reg_rdata_reg == 8'h00)
        else $error("read data outside read answer");
    AST_RESET_VECTOR: assert property (mem_req_reg.rd && !seen_reg |-> mem_req_reg.addr == 11'h000)
        else $error("first fetch not at address zero");

    COV_PUSH: cover property (stack_push_reg.push);
    COV_INT: cover property (int_ack_reg);
    COV_READ: cover property ($past(reg_req.rd) && reg_rdata_reg != 8'h00);
endmodule

bind mcu_fetch_pipeline_pc mcu_fetch_pipeline_pc_asserts #(.SLOW_DIV(SLOW_DIV)) u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata_reg(reg_rdata_reg),
    .mem_data(mem_data), .mem_req_reg(mem_req_reg), .int_req(int_req), .int_vec(int_vec),
    .int_ack_reg(int_ack_reg), .stack_push_reg(stack_push_reg),
    .instruction_phase_clocks(instruction_phase_clocks),
    .program_counter_high_bits(program_counter_high_bits)
);

// File: bench/prog_mem_model.sv
/*
 Behavioural program memory answering fetches after LAT clocks.
 Assumes LAT of at most 2 clocks, so the word stands before the next cycle end.
*/
`timescale 1ns/1ns
module prog_mem_model #(
    parameter int LAT = 2
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire mcu_pc_pkg::fetch_req_t fetch_req,
    output logic [15:0] mem_data
);
    logic [15:0] words [0:2047];
    logic [10:0] pend_addr;
    int wait_cnt;

    initial begin
        foreach (words[j]) begin
            words[j] = 16'h0000;
        end
    end

    // Word stays garbled until the access time has run out
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_data <= 16'hA5A5;
            wait_cnt <= 0;
            pend_addr <= 11'h000;
        end else if (fetch_req.rd) begin
            pend_addr <= fetch_req.addr;
            wait_cnt <= LAT;
            mem_data <= ~mem_data;
        end else if (wait_cnt == 1) begin
            mem_data <= words[pend_addr];
            wait_cnt <= 0;
        end else if (wait_cnt > 1) begin
            wait_cnt <= wait_cnt - 1;
            mem_data <= ~mem_data;
        end
    end
endmodule

// File: bench/mcu_fetch_pipeline_pc_tb.sv
/*
 Self-checking bench: program run, interrupt, register port, oscillator switch.
 Assumes the program memory model in prog_mem_model and SLOW_DIV of 2.
*/
`timescale 1ns/1ns
module mcu_fetch_pipeline_pc_tb;
    logic sys_clk;
    logic rst_n;
    logic int_req;
    logic int_ack;
    logic [10:0] int_vec;
    logic [7:0] rdata;
    logic [15:0] mem_data;
    logic [3:0] phases;
    logic [3:0] fetch_phase;
    logic [2:0] high;
    mcu_pc_pkg::reg_req_t reg_req;
    mcu_pc_pkg::fetch_req_t mem_req;
    mcu_pc_pkg::stack_push_t push;
    logic [10:0] fq[$];
    logic [10:0] pq[$];
    logic [10:0] exp_seq [12] = '{11'h000, 11'h001, 11'h002, 11'h003, 11'h004, 11'h005,
                                 11'h10A, 11'h10B, 11'h103, 11'h104, 11'h200, 11'h201};
    time prev_t;
    time gap;
    int fails;
    int check_count;

    mcu_fetch_pipeline_pc #(.SLOW_DIV(2)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata_reg(rdata),
        .mem_data(mem_data), .mem_req_reg(mem_req), .int_req(int_req), .int_vec(int_vec),
        .int_ack_reg(int_ack), .stack_push_reg(push), .instruction_phase_clocks(phases),
        .program_counter_high_bits(high)
    );
    prog_mem_model #(.LAT(2)) pmem (
        .sys_clk(sys_clk), .rst_n(rst_n), .fetch_req(mem_req), .mem_data(mem_data)
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Mid-cycle sampling keeps clear of the launching edge
    always @(negedge sys_clk) begin
        if (rst_n === 1'b1 && mem_req.rd === 1'b1) begin
            fq.push_back(mem_req.addr);
            fetch_phase = phases;
            gap = $time - prev_t;
            prev_t = $time;
        end
        if (rst_n === 1'b1 && push.push === 1'b1) begin
            pq.push_back(push.ret_addr);
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_fetch(input int n);
        for (int i = 0; i < 3000 && fq.size() < n; i++) begin
            @(negedge sys_clk);
        end
        if (fq.size() < n) begin
            fails++;
            end_of_test();
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge sys_clk);
        reg_req <= '0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge sys_clk);
        reg_req <= '0;
        @(negedge sys_clk);
        d = rdata;
    endtask

    // Searches fetches from a start index; a miss yields an unknown address
    task automatic expect_fetch(input logic [10:0] a, input int from, output int k);
        k = -1;
        for (int j = from; j < fq.size(); j++) begin
            if (fq[j] === a && k < 0) begin
                k = j;
            end
        end
        check(k < 0 ? 16'hXXXX : 16'(fq[k]), 16'(a));
    endtask

    initial begin
        int i;
        int k;
        int n;
        logic [7:0] d;
        logic [10:0] a;
        reg_req = '0;
        int_req = 1'b0;
        int_vec = 11'h54C;
        rst_n = 1'b0;
        fails = 0;
        check_count = 0;
        prev_t = 0;
        gap = 0;
        #1;
        pmem.words[0] = 16'hE000;
        pmem.words[1] = 16'h8000;
        pmem.words[2] = 16'hE055;
        pmem.words[3] = 16'h2003;
        pmem.words[4] = 16'h410A;
        pmem.words[5] = 16'hE0AA;
        pmem.words[11'h10A] = 16'hA000;
        pmem.words[11'h10B] = 16'hE0AA;
        pmem.words[11'h103] = 16'h6200;
        pmem.words[11'h104] = 16'hE0AA;
        pmem.words[11'h200] = 16'hC000;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        wait_fetch(12);
        for (i = 0; i < 12; i++) begin
            check(16'(fq[i]), 16'(exp_seq[i]));
        end
        check(16'(gap), 16'h0028);
        check(16'(fetch_phase), 16'h0001);
        reg_read(mcu_pc_pkg::REG_ACC, d);
        check(16'(d), 16'h0003);
        check(16'(pq[0]), 16'h0104);
        n = fq.size();
        @(posedge sys_clk);
        int_req <= 1'b1;
        for (i = 0; i < 200 && int_ack !== 1'b1; i++) begin
            @(negedge sys_clk);
        end
        check(16'(int_ack), 16'h0001);
        @(posedge sys_clk);
        int_req <= 1'b0;
        wait_fetch(fq.size() + 3);
        expect_fetch(11'h54C, n, k);
        check(16'(pq[1]), k > 0 ? 16'(fq[k-1]) : 16'hXXXX);
        reg_write(mcu_pc_pkg::REG_PCL, 8'h20);
        n = fq.size();
        wait_fetch(n + 3);
        expect_fetch(11'h520, n - 1, k);
        wait_fetch(fq.size() + 1);
        a = fq[$] + 11'h001;
        check(16'(high), 16'h0005);
        reg_read(mcu_pc_pkg::REG_PCL, d);
        check(16'(d), 16'(a[7:0]));
        reg_write(mcu_pc_pkg::REG_ACC, 8'h77);
        reg_read(mcu_pc_pkg::REG_ACC, d);
        check(16'(d), 16'h0002);
        reg_read(4'hF, d);
        check(16'(d), 16'h0000);
        reg_read(mcu_pc_pkg::REG_CLK_CTRL, d);
        check(16'(d), 16'h0000);
        reg_write(mcu_pc_pkg::REG_CLK_CTRL, 8'h01);
        wait_fetch(fq.size() + 3);
        check(16'(gap), 16'h0050);
        reg_read(mcu_pc_pkg::REG_STATUS, d);
        check(16'(d[4]), 16'h0001);
        end_of_test();
    end
endmodule
